// ---- rtl/uds_pkg.sv ----
// Shared constants and types for the unit dispatch and trap support block.
// Assumes a single core clock and one APB register slave.
package uds_pkg;
  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_FLAG = 8'h00;
  localparam logic [7:0] OFF_ENABLE = 8'h04;
  localparam logic [7:0] OFF_CLEAR = 8'h08;
  localparam logic [7:0] OFF_VTP = 8'h0C;
  localparam logic [7:0] OFF_CSR = 8'h10;
  localparam logic [7:0] OFF_IRP = 8'h14;
  localparam logic [7:0] OFF_NRP = 8'h18;
  // ---------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------
  localparam int NUM_IRQ = 16;
  localparam int NMI_BIT = 1;
  localparam int FIRST_MASKABLE = 4;
  localparam logic [15:0] IRQ_IMPL = 16'hFFF2;
  localparam int GIE_BIT = 0;
  localparam int PRIOR_GLOBAL_IRQ_ENABLE_BIT = 1;
  localparam int VTP_NUM_LSB = 5;
  localparam int VTP_BASE_LSB = 10;
  localparam logic [15:0] FLAG_RST = 16'h0000;
  localparam logic [15:0] ENABLE_RST = 16'h0000;
  localparam logic [21:0] VTP_BASE_RST = 22'h000000;
  localparam logic [31:0] PTR_RST = 32'h00000000;
  // ---------------------------------------------------------------
  // Timing counts in execute packets / cycles, and the branch displacement width
  // ---------------------------------------------------------------
  localparam logic [2:0] DELAY_SLOTS = 3'h5;
  localparam logic [2:0] DRAIN_CYC = 3'h4;
  localparam int DISP_W = 21;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    C_NOP, C_IDLE, C_ADDSUB, C_MV, C_CMP, C_LOGIC, C_SHIFT, C_MVK,
    C_ADDK, C_BDISP, C_BREG, C_BIRP, C_BNRP, C_MVC, C_MPY, C_LDST,
    C_LDST15, C_ADDA
  } uds_class_t;
  typedef enum logic [1:0] {U_L, U_M, U_S, U_D} uds_unit_t;
  typedef enum logic [1:0] {S_RUN = 2'b00, S_DRAIN = 2'b01, S_VEC = 2'b11} uds_state_t;
  typedef struct packed {
    logic vld;
    uds_class_t cls;
    uds_unit_t unit;
    logic side_b;
    logic [2:0] creg;
    logic [31:0] pc;
    logic [DISP_W-1:0] disp;
    logic [31:0] reg_tgt;
  } uds_issue_t;
  typedef struct packed {
    logic vld;
    logic exec;
    logic annul;
    logic unit_err;
  } uds_result_t;
endpackage

// ---- rtl/uds_dispatch.sv ----
// Unit dispatch, predication, branch delay slots and interrupt registers.
// Assumes packets arrive one per cycle on iss and APB is zero-wait capable.
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module uds_dispatch (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [uds_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire uds_pkg::uds_issue_t iss,
  input wire logic [4:0] cond_nz,
  input wire logic [uds_pkg::NUM_IRQ-1:0] irq_in,
  input wire logic [31:0] resume_pc,
  output uds_pkg::uds_result_t res,
  output logic redirect_vld,
  output logic [31:0] redirect_pc,
  output logic irq_take
);
  import uds_pkg::*;

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_ff1_reg, rstn;
  // Two stages so release is clean against the clock
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_ff1_reg <= 1'b0;
      rstn <= 1'b0;
    end else begin
      rst_ff1_reg <= 1'b1;
      rstn <= rst_ff1_reg;
    end
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [15:0] flag_reg, enable_reg;
  logic [21:0] vtp_base_reg;
  logic gie_reg, prior_global_irq_enable_reg, in_nmi_reg;
  logic [31:0] irp_reg, nrp_reg;
  logic [2:0] slot_cnt_reg, drain_cnt_reg;
  logic [31:0] tgt_reg;
  logic [4:0] vec_num_reg;
  uds_state_t st_reg;

  // ---------------------------------------------------------------
  // Dispatch decode
  // ---------------------------------------------------------------
  // Unit legality per class; unknown class codes are refused
  function automatic logic unit_ok(uds_class_t c, uds_unit_t u, logic b);
    unique case (c)
      C_NOP, C_IDLE: unit_ok = 1'b1;
      C_ADDSUB: unit_ok = (u != U_M);
      C_MV: unit_ok = (u == U_S) || (u == U_D);
      C_CMP: unit_ok = (u == U_L);
      C_LOGIC: unit_ok = (u == U_L) || (u == U_S);
      C_SHIFT, C_MVK, C_ADDK, C_BDISP: unit_ok = (u == U_S);
      C_BREG, C_BIRP, C_BNRP, C_MVC: unit_ok = (u == U_S) && b;
      C_MPY: unit_ok = (u == U_M);
      C_LDST, C_ADDA: unit_ok = (u == U_D);
      C_LDST15: unit_ok = (u == U_D) && b;
      default: unit_ok = 1'b0;
    endcase
  endfunction

  logic pred_true, legal, exec_now, is_br;
  logic [31:0] disp_tgt, br_tgt;
  // Codes 6 and 7 name no condition register, so they count as illegal
  always_comb begin
    pred_true = (iss.creg == 3'h0) ||
      ((iss.creg <= 3'h5) && cond_nz[3'(iss.creg - 3'h1)]);
    legal = unit_ok(iss.cls, iss.unit, iss.side_b) && (iss.creg <= 3'h5);
    exec_now = iss.vld && legal && pred_true && (st_reg == S_RUN);
    is_br = (iss.cls == C_BDISP) || (iss.cls == C_BREG) ||
      (iss.cls == C_BIRP) || (iss.cls == C_BNRP);
    disp_tgt = iss.pc + {{9{iss.disp[DISP_W-1]}}, iss.disp, 2'b00};
    unique case (iss.cls)
      C_BDISP: br_tgt = disp_tgt;
      C_BIRP: br_tgt = irp_reg;
      C_BNRP: br_tgt = nrp_reg;
      default: br_tgt = iss.reg_tgt;
    endcase
  end

  // Registered dispatch verdict
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      res <= '0;
    end else begin
      res.vld <= iss.vld;
      res.exec <= exec_now;
      res.annul <= iss.vld && !exec_now;
      res.unit_err <= iss.vld && !legal;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt selection
  // ---------------------------------------------------------------
  logic [15:0] pend;
  logic [4:0] hp_num;
  logic take_n, take_m;
  // Lowest number wins; NMI sits below every maskable line
  always_comb begin
    pend = flag_reg & enable_reg & IRQ_IMPL;
    hp_num = 5'h00;
    for (int i = NUM_IRQ - 1; i >= NMI_BIT; i--) begin
      if (pend[i]) begin
        hp_num = 5'(i);
      end
    end
    take_n = pend[NMI_BIT] && !in_nmi_reg && (st_reg == S_RUN);
    take_m = (pend[15:FIRST_MASKABLE] != 12'h000) && gie_reg &&
      !in_nmi_reg && !pend[NMI_BIT] && (st_reg == S_RUN);
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  logic setup, wr_acc, mapped;
  logic [31:0] rd_val;
  always_comb begin
    setup = psel && !penable;
    wr_acc = psel && penable && pready && pwrite && !pslverr;
    mapped = (paddr <= OFF_NRP) && (paddr[1:0] == 2'b00);
    unique case (paddr)
      OFF_FLAG: rd_val = {16'h0000, flag_reg};
      OFF_ENABLE: rd_val = {16'h0000, enable_reg};
      OFF_VTP: rd_val = {vtp_base_reg, hp_num, 5'h00};
      OFF_CSR: rd_val = {30'h00000000, prior_global_irq_enable_reg, gie_reg};
      OFF_IRP: rd_val = irp_reg;
      OFF_NRP: rd_val = nrp_reg;
      default: rd_val = 32'h00000000;
    endcase
  end

  // One wait-free access phase; data and error are captured at setup
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata <= rd_val;
      end
    end
  end

  // ---------------------------------------------------------------
  // Flag and enable registers
  // ---------------------------------------------------------------
  logic [15:0] clr_mask, take_mask;
  always_comb begin
    clr_mask = (wr_acc && paddr == OFF_CLEAR) ? pwdata[15:0] : 16'h0000;
    take_mask = 16'h0000;
    if (take_n || take_m) begin
      take_mask[4'(hp_num)] = 1'b1;
    end
  end

  // New events win over a clear landing in the same cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      flag_reg <= FLAG_RST;
    end else begin
      flag_reg <= ((flag_reg & ~clr_mask & ~take_mask) | irq_in) & IRQ_IMPL;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      enable_reg <= ENABLE_RST;
      vtp_base_reg <= VTP_BASE_RST;
    end else begin
      if (wr_acc && paddr == OFF_ENABLE) begin
        enable_reg <= pwdata[15:0] & IRQ_IMPL;
      end
      if (wr_acc && paddr == OFF_VTP) begin
        vtp_base_reg <= pwdata[31:VTP_BASE_LSB];
      end
    end
  end

  // ---------------------------------------------------------------
  // Control status, return pointers, NMI service flag
  // ---------------------------------------------------------------
  // Hardware entry and return outrank a software write in the same cycle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gie_reg <= 1'b0;
      prior_global_irq_enable_reg <= 1'b0;
      in_nmi_reg <= 1'b0;
      irp_reg <= PTR_RST;
      nrp_reg <= PTR_RST;
    end else begin
      if (wr_acc && paddr == OFF_CSR) begin
        gie_reg <= pwdata[GIE_BIT];
        prior_global_irq_enable_reg <= pwdata[PRIOR_GLOBAL_IRQ_ENABLE_BIT];
      end
      if (wr_acc && paddr == OFF_IRP) begin
        irp_reg <= pwdata;
      end
      if (wr_acc && paddr == OFF_NRP) begin
        nrp_reg <= pwdata;
      end
      if (exec_now && iss.cls == C_BIRP) begin
        gie_reg <= prior_global_irq_enable_reg;
      end
      if (exec_now && iss.cls == C_BNRP) begin
        in_nmi_reg <= 1'b0;
      end
      if (take_m) begin
        irp_reg <= resume_pc;
        prior_global_irq_enable_reg <= gie_reg;
        gie_reg <= 1'b0;
      end
      if (take_n) begin
        nrp_reg <= resume_pc;
        in_nmi_reg <= 1'b1;
        prior_global_irq_enable_reg <= gie_reg;
        gie_reg <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Interrupt sequencer and branch delay slots
  // ---------------------------------------------------------------
  // A taken interrupt drops any branch in flight; it is refetched on return
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= S_RUN;
      drain_cnt_reg <= 3'h0;
      vec_num_reg <= 5'h00;
      irq_take <= 1'b0;
    end else begin
      irq_take <= take_n || take_m;
      unique case (st_reg)
        S_RUN: begin
          if (take_n || take_m) begin
            st_reg <= S_DRAIN;
            drain_cnt_reg <= DRAIN_CYC;
            vec_num_reg <= hp_num;
          end
        end
        S_DRAIN: begin
          drain_cnt_reg <= drain_cnt_reg - 3'h1;
          if (drain_cnt_reg == 3'h1) begin
            st_reg <= S_VEC;
          end
        end
        S_VEC: st_reg <= S_RUN;
        default: st_reg <= S_RUN;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      slot_cnt_reg <= 3'h0;
      tgt_reg <= PTR_RST;
      redirect_vld <= 1'b0;
      redirect_pc <= PTR_RST;
    end else begin
      redirect_vld <= 1'b0;
      if (st_reg == S_VEC) begin
        redirect_vld <= 1'b1;
        redirect_pc <= {vtp_base_reg, vec_num_reg, 5'h00};
        slot_cnt_reg <= 3'h0;
      end else if (st_reg == S_DRAIN || take_n || take_m) begin
        slot_cnt_reg <= 3'h0;
      end else if (exec_now && is_br) begin
        slot_cnt_reg <= DELAY_SLOTS;
        tgt_reg <= br_tgt;
      end else if (iss.vld && slot_cnt_reg != 3'h0) begin
        slot_cnt_reg <= slot_cnt_reg - 3'h1;
        if (slot_cnt_reg == 3'h1) begin
          redirect_vld <= 1'b1;
          redirect_pc <= tgt_reg;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  sequence s_br_start;
    exec_now && is_br && !take_n && !take_m;
  endsequence
  sequence s_clr_wr(int n);
    wr_acc && paddr == OFF_CLEAR && pwdata[n] && !irq_in[n];
  endsequence

  a_pred_annul: assert property (iss.vld && iss.creg inside {[3'h1:3'h5]} &&
    !cond_nz[3'(iss.creg - 3'h1)] |=> res.annul && !res.exec)
    else $error("zero predicate not annulled");
  a_mpy_unit: assert property (iss.vld && iss.cls == C_MPY && iss.unit != U_M
    |=> res.unit_err && !res.exec) else $error("multiply off the multiply unit");
  a_bside_only: assert property (iss.vld && !iss.side_b &&
    iss.cls inside {C_BREG, C_MVC, C_LDST15} |=> res.unit_err)
    else $error("B side only class accepted on A side");
  a_cmp_unit: assert property (iss.vld && iss.cls == C_CMP && iss.creg == 3'h0 &&
    st_reg == S_RUN |=> res.exec == $past(iss.unit == U_L))
    else $error("compare unit check wrong");
  a_slot_load: assert property (s_br_start |=> slot_cnt_reg == 3'h5 &&
    tgt_reg == $past(br_tgt)) else $error("branch slots not armed");
  a_disp_target: assert property ((s_br_start and (iss.cls == C_BDISP)) |=>
    tgt_reg == $past(iss.pc) + {{9{$past(iss.disp[20])}}, $past(iss.disp), 2'b00})
    else $error("displacement target wrong");
  a_slot_redirect: assert property (slot_cnt_reg == 3'h1 && iss.vld &&
    st_reg == S_RUN && !take_n && !take_m && !exec_now
    |=> redirect_vld && redirect_pc == $past(tgt_reg)) else $error("redirect missed");
  a_clear_bit: assert property (s_clr_wr(4) |=> !flag_reg[4])
    else $error("clear write left flag set");
  a_irp_write: assert property (wr_acc && paddr == OFF_IRP && !take_m
    |=> irp_reg == $past(pwdata)) else $error("return pointer not written");
  a_gie_block: assert property (!gie_reg |-> !take_m)
    else $error("maskable taken with global enable low");
  a_nmi_nest: assert property (in_nmi_reg |-> !take_n && !take_m)
    else $error("interrupt preempted NMI service");
  a_drain_annul: assert property (take_n || take_m |=>
    (st_reg == S_DRAIN && !exec_now) [*4] ##1 st_reg == S_VEC)
    else $error("drain window wrong");
  a_vtp_read: assert property (setup && !pwrite && paddr == OFF_VTP |=>
    prdata[9:5] == $past(hp_num)) else $error("vector number wrong");
endmodule

// ---- dv/uds_dispatch_bench.sv ----
// Self-checking bench for the unit dispatch and trap support block.
// Assumes a one-cycle APB access and res one cycle after each issue.
`timescale 1ns/1ps
module unit_dispatch_and_trap_support_bench;
  import uds_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] resume_pc = '0;
  logic [31:0] prdata, redirect_pc, rd, t, nx_pc;
  logic pready, pslverr, redirect_vld, irq_take, er;
  uds_issue_t iss = '0;
  logic [4:0] cond_nz = '0;
  logic [4:0] nx_cond = '0;
  logic [20:0] nx_disp = '0;
  logic [NUM_IRQ-1:0] irq_in = '0;
  uds_result_t res;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;
  int takes = 0;
  int seed = 32'hdfb6329d;
  logic [7:0] offs [7] = '{OFF_FLAG, OFF_ENABLE, OFF_CLEAR, OFF_VTP, OFF_CSR, OFF_IRP, OFF_NRP};

  uds_dispatch DUT (.core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .iss(iss), .cond_nz(cond_nz), .irq_in(irq_in), .resume_pc(resume_pc),
    .res(res), .redirect_vld(redirect_vld), .redirect_pc(redirect_pc), .irq_take(irq_take));

  // 100 MHz core clock
  always #5 core_clk = ~core_clk;

  // Cycle ceiling and take counter; a hang ends the run as a failure
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (irq_take === 1'b1) takes <= takes + 1;
    if (cycles == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // Checking and driving tasks
  // ---------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check32(input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t exp %h got %h", $time, exp, got);
    end
  endtask

  task automatic check_res(input uds_result_t exp);
    check32({28'h0, exp}, {28'h0, res});
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_fail++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check32(exp, rd);
  endtask

  // Issue stays valid until the next task lowers or replaces it
  task automatic issue(input uds_class_t c, input uds_unit_t u, input logic sb,
    input logic [2:0] cr);
    @(posedge core_clk);
    iss.vld <= 1'b1;
    iss.cls <= c;
    iss.unit <= u;
    iss.side_b <= sb;
    iss.creg <= cr;
    iss.pc <= nx_pc;
    iss.disp <= nx_disp;
    iss.reg_tgt <= ~nx_pc;
    cond_nz <= nx_cond;
  endtask

  task automatic idle_cyc();
    @(posedge core_clk);
    iss.vld <= 1'b0;
  endtask

  // Five delay-slot packets; no redirect may appear before the fifth is taken
  task automatic slots();
    for (int s = 0; s < 5; s++) begin
      issue(C_NOP, U_L, 1'b0, 3'd0);
      @(negedge core_clk);
      check32(32'h0, {31'h0, redirect_vld});
    end
    idle_cyc();
  endtask

  task automatic wait_redirect(input logic [31:0] exp);
    for (int n = 0; n < 10 && redirect_vld !== 1'b1; n++) @(negedge core_clk);
    check32(32'h1, {31'h0, redirect_vld});
    check32(exp, redirect_pc);
  endtask

  // ---------------------------------------------------------------
  // Expected dispatch outcome
  // ---------------------------------------------------------------
  function automatic logic legal(uds_class_t c, uds_unit_t u, logic sb);
    case (c)
      C_NOP, C_IDLE: return 1'b1;
      C_ADDSUB: return u != U_M;
      C_MV: return u inside {U_S, U_D};
      C_CMP: return u == U_L;
      C_LOGIC: return u inside {U_L, U_S};
      C_SHIFT, C_MVK, C_ADDK, C_BDISP: return u == U_S;
      C_BREG, C_BIRP, C_BNRP, C_MVC: return u == U_S && sb;
      C_MPY: return u == U_M;
      C_LDST, C_ADDA: return u == U_D;
      C_LDST15: return u == U_D && sb;
      default: return 1'b0;
    endcase
  endfunction

  function automatic uds_result_t exp_res(uds_class_t c, uds_unit_t u, logic sb,
    logic [2:0] cr);
    logic ok, go;
    ok = legal(c, u, sb) && cr < 3'd6;
    go = ok && (cr == 3'd0 || nx_cond[cr - 3'd1]);
    return '{1'b1, go, !go, !ok};
  endfunction

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    int r, cv;
    uds_class_t c;
    uds_unit_t u;
    logic [2:0] cr;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge core_clk);
    foreach (offs[i]) rd_chk(offs[i], 32'h0);
    apb(1'b1, 8'h1C, 32'hFFFFFFFF);
    check32(32'h1, {31'h0, er});
    apb(1'b1, 8'h06, 32'hFFFFFFFF);
    check32(32'h1, {31'h0, er});
    rd_chk(OFF_ENABLE, 32'h0);
    // Random classes, units and predicates; first eight walk every creg
    for (int k = 0; k < 90; k++) begin
      r = $random(seed);
      cv = {16'h0, r[31:16]} % 18;
      c = uds_class_t'(cv[4:0]);
      u = uds_unit_t'(r[1:0]);
      cr = (k < 8) ? k[2:0] : r[5:3];
      nx_cond = r[10:6];
      nx_pc = {$random(seed)} & 32'hFFFFFFFC;
      issue(c, u, r[2], cr);
      idle_cyc();
      @(negedge core_clk);
      check_res(exp_res(c, u, r[2], cr));
    end
    // Displacement branch, random and most negative offset
    for (int k = 0; k < 2; k++) begin
      nx_pc = {$random(seed)} & 32'hFFFFFFFC;
      nx_disp = k ? 21'h100000 : 21'($random(seed));
      t = nx_pc + {{9{nx_disp[20]}}, nx_disp, 2'b00};
      issue(C_BDISP, U_S, k[0], 3'd0);
      slots();
      wait_redirect(t);
    end
    // Polling with global enable low
    apb(1'b1, OFF_CSR, 32'h0);
    apb(1'b1, OFF_ENABLE, 32'h1220);
    @(posedge core_clk);
    irq_in <= 16'h5200;
    @(posedge core_clk);
    irq_in <= 16'h0;
    rd_chk(OFF_FLAG, 32'h5200);
    rd_chk(OFF_ENABLE, 32'h1220);
    rd_chk(OFF_VTP, 32'h9 << VTP_NUM_LSB);
    apb(1'b1, OFF_CLEAR, 32'h0200);
    rd_chk(OFF_FLAG, 32'h5000);
    rd_chk(OFF_VTP, 32'hC << VTP_NUM_LSB);
    rd_chk(OFF_CLEAR, 32'h0);
    apb(1'b1, OFF_CLEAR, 32'hFFFF);
    rd_chk(OFF_FLAG, 32'h0);
    check32(32'h0, takes);
    // Return pointer written by software, then return branch
    t = {$random(seed)} & 32'hFFFFFFFC;
    apb(1'b1, OFF_IRP, t);
    rd_chk(OFF_IRP, t);
    issue(C_BIRP, U_S, 1'b1, 3'd0);
    slots();
    wait_redirect(t);
    // Taken maskable interrupt: drain, vector, saved state, return
    t = $random(seed);
    apb(1'b1, OFF_VTP, {t[31:10], 10'h0});
    apb(1'b1, OFF_ENABLE, 32'h0040);
    apb(1'b1, OFF_CSR, 32'h1);
    nx_pc = {$random(seed)} & 32'hFFFFFFFC;
    resume_pc <= nx_pc;
    irq_in <= 16'h0040;
    @(posedge core_clk);
    irq_in <= 16'h0;
    for (int n = 0; n < 10 && irq_take !== 1'b1; n++) @(negedge core_clk);
    check32(32'h1, {31'h0, irq_take});
    issue(C_ADDSUB, U_L, 1'b0, 3'd0);
    idle_cyc();
    @(negedge core_clk);
    check_res('{1'b1, 1'b0, 1'b1, 1'b0});
    wait_redirect({t[31:10], 5'd6, 5'h0});
    rd_chk(OFF_CSR, 32'h2);
    rd_chk(OFF_IRP, nx_pc);
    rd_chk(OFF_FLAG, 32'h0);
    apb(1'b1, OFF_ENABLE, 32'h0);
    issue(C_BIRP, U_S, 1'b1, 3'd0);
    slots();
    wait_redirect(nx_pc);
    rd_chk(OFF_CSR, 32'h3);
    apb(1'b0, OFF_CSR, 32'h0);
    check32(32'h1, rd & 32'h1);
    // NMI preempts a maskable service; nothing preempts the NMI service
    cv = takes;
    apb(1'b1, OFF_ENABLE, 32'h0042);
    resume_pc <= 32'h00000100;
    irq_in <= 16'h0040;
    @(posedge core_clk);
    irq_in <= 16'h0002;
    @(posedge core_clk);
    irq_in <= 16'h0040;
    @(posedge core_clk);
    irq_in <= 16'h0;
    repeat (20) @(posedge core_clk);
    check32(cv + 2, takes);
    rd_chk(OFF_NRP, 32'h100);
    // Global enable back on: only the NMI service flag holds the maskable off
    apb(1'b1, OFF_CSR, 32'h1);
    repeat (10) @(posedge core_clk);
    check32(cv + 2, takes);
    issue(C_BNRP, U_S, 1'b1, 3'd0);
    idle_cyc();
    repeat (10) @(posedge core_clk);
    check32(cv + 3, takes);
    finish_test();
  end
endmodule
